// ==== pkg/tksc_pkg.sv ====
package tksc_pkg;
  // register indices, byte address is four times the index
  localparam logic [15:0] SEQ_IDX  = 16'ha019;
  localparam logic [15:0] AVG_IDX  = 16'ha01a;
  localparam logic [15:0] CTRL_IDX = 16'ha020;
  localparam logic [15:0] STAT_IDX = 16'ha021;
  localparam logic [15:0] MASK_IDX = 16'ha022;
  localparam logic [15:0] TRIP_IDX = 16'ha023;
  localparam logic [15:0] REF_IDX  = 16'ha024;
  localparam logic [15:0] LOW_IDX  = 16'ha025;
  localparam logic [15:0] HIGH_IDX = 16'ha026;
  // values after reset
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // sequence_timing_config fields
  localparam int RPT_LSB    = 6;
  localparam int SETTLE_LSB = 4;
  localparam int IDLE_LSB   = 2;
  localparam int NOISE_LSB  = 0;
  // averaging_threshold_config fields
  localparam int SLOW_LSB    = 6;
  localparam int CYC_LSB     = 3;
  localparam int REFERENCE_INIT_SEL_BIT = 2;
  localparam int COMPARE_VALUE_SEL_BIT  = 1;
  localparam int AUTOLF_BIT  = 0;
  // control register bits
  localparam int START_BIT   = 0;
  localparam int AUTO_BIT    = 1;
  localparam int IDLE_EN_BIT = 2;
  // status register bits, busy is read only
  localparam int BUSY_BIT  = 0;
  localparam int DONE_BIT  = 1;
  localparam int TRIP_BIT  = 2;
  localparam int NOISE_BIT = 3;
  // timing units in touch-key clock periods, then minimum averaging shift and default divider
  localparam int SETTLE_UNIT   = 4;
  localparam int IDLE_UNIT     = 256;
  localparam int NOISE_UNIT    = 8;
  localparam int AVG_MIN_SHIFT = 5;
  localparam int TK_DIV_DEF    = 2;
  // engine states, gray from idle through delay, settle and count to done
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DELAY  = 3'b001,
    ST_SETTLE = 3'b011,
    ST_COUNT  = 3'b010,
    ST_DONE   = 3'b110
  } tksc_state_type;
  // cycles of one sequence for each cycle code
  function automatic logic [16:0] tksc_cycles(input logic [2:0] code);
    unique case (code)
      3'd0:    return 17'h0_0400;
      3'd1:    return 17'h0_0800;
      3'd2:    return 17'h0_1000;
      3'd3:    return 17'h0_2000;
      3'd4:    return 17'h0_3000;
      3'd5:    return 17'h0_4000;
      3'd6:    return 17'h0_8000;
      default: return 17'h1_0000;
    endcase
  endfunction
endpackage

// ==== core/tksc_core.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - repeat field gives one, 4, 8, 16 sequences
// - settle for (field+1)*4 touch-key periods first
// - auto idle of (field+1)*256 periods once before each conversion, not between repeats
// - filter off at 00, else ignores long noise
// - cycle counter keeps running during filtered noise
// - auto reference follows moving average of 32..256 conversions
// - cycle field selects sequence cycle count
// - conversion ends exactly at the cycle count
// - optionally load first auto low count as reference
// - compare value is threshold or threshold plus reference
// - auto filter enable zero disables auto filtering
// - software starts, hardware clears start at completion
// - done interrupt only after all repeats complete, noise interrupt can come mid-count
// - auto trip over threshold raises interrupt and wakeup
// - auto start idle only while its enable set
module tksc_core
  import tksc_pkg::*;
#(
  parameter int TK_DIV = TK_DIV_DEF
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // electrode comparator
  input  wire logic        sense_in,
  // events
  output logic             irq,
  output logic             wakeup
);
  // apb registers
  logic [31:0]    prdata_r, prdata_nxt;
  logic           pready_r, pready_nxt;
  logic           pslverr_r, pslverr_nxt;
  // software registers
  logic [7:0]     seq_r, seq_nxt;    // sequence_timing_config
  logic [7:0]     avg_r, avg_nxt;    // averaging_threshold_config
  logic [2:0]     ctrl_r, ctrl_nxt;  // start, auto, idle enable
  logic [3:1]     stat_r, stat_nxt;  // sticky events
  logic [3:0]     mask_r, mask_nxt;  // interrupt mask
  logic [15:0]    trip_r, trip_nxt;  // trip_level
  logic [15:0]    ref_r, ref_nxt;    // reference level
  logic [15:0]    low_r, low_nxt;    // low_duty_total
  logic [15:0]    high_r, high_nxt;  // high_duty_total
  logic           irq_r, irq_nxt;
  logic           wake_r, wake_nxt;
  // engine state
  tksc_state_type st_r, st_nxt;
  logic [16:0]    cnt_r, cnt_nxt;    // down counter of periods
  logic [4:0]     pass_r, pass_nxt;  // sequence index
  logic [20:0]    alo_r, alo_nxt;    // low duty accumulator
  logic [20:0]    ahi_r, ahi_nxt;    // high duty accumulator
  logic [4:0]     run_r, run_nxt;    // same-level run length
  logic           lvl_r, lvl_nxt;    // last sampled level
  logic           first_r, first_nxt;
  logic [7:0]     div_r, div_nxt;    // touch-key clock divider
  // sense synchroniser
  logic           s1_r, s2_r;
  // decoded helpers
  logic           setup, wr, hit;
  logic [15:0]    idx;
  logic           tick, auto, filt_on, noisy, over;
  logic [1:0]     rpt, set_sel, idle_sel, nf_len, slow;
  logic [4:0]     pass_last;
  logic [15:0]    low_sat;
  logic [16:0]    cmp_val;
  logic signed [17:0] diff, step, sum;

  // field split
  assign rpt      = seq_r[RPT_LSB+:2];
  assign set_sel  = seq_r[SETTLE_LSB+:2];
  assign idle_sel = seq_r[IDLE_LSB+:2];
  assign nf_len   = seq_r[NOISE_LSB+:2];
  assign slow     = avg_r[SLOW_LSB+:2];
  assign auto     = ctrl_r[AUTO_BIT];
  assign idx      = paddr[17:2];
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pready_r & pwrite;
  assign tick     = (div_r == 8'(TK_DIV - 1));

  // last sequence index for the repeat code
  always_comb begin
    unique case (rpt)
      2'd0:    pass_last = 5'd0;
      2'd1:    pass_last = 5'd3;
      2'd2:    pass_last = 5'd7;
      default: pass_last = 5'd15;
    endcase
  end

  // noise filter: a run longer than len*8 is noise
  always_comb begin
    filt_on = (nf_len != 2'd0) && (!auto || avg_r[AUTOLF_BIT]);
    noisy   = filt_on && (32'(run_r) >= 32'(nf_len) * NOISE_UNIT);
  end

  // saturated total, compare value and moving average
  always_comb begin
    low_sat = (alo_r[20:16] != 5'd0) ? 16'hffff : alo_r[15:0];
    cmp_val = {1'b0, trip_r};
    if (avg_r[COMPARE_VALUE_SEL_BIT]) begin
      cmp_val = {1'b0, trip_r} + {1'b0, ref_r};
    end
    over = {1'b0, low_sat} > cmp_val;
    diff = $signed({2'b00, low_sat}) - $signed({2'b00, ref_r});
    step = diff >>> (AVG_MIN_SHIFT + 32'(slow));
    sum  = $signed({2'b00, ref_r}) + step;
  end

  // apb slave next values, zero wait states
  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    hit         = 1'b1;
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      unique case (idx)
        SEQ_IDX:  prdata_nxt[7:0]  = seq_r;
        AVG_IDX:  prdata_nxt[7:0]  = avg_r;
        CTRL_IDX: prdata_nxt[2:0]  = ctrl_r;
        STAT_IDX: prdata_nxt[3:0]  = {stat_r, st_r != ST_IDLE};
        MASK_IDX: prdata_nxt[3:0]  = mask_r;
        TRIP_IDX: prdata_nxt[15:0] = trip_r;
        REF_IDX:  prdata_nxt[15:0] = ref_r;
        LOW_IDX:  prdata_nxt[15:0] = low_r;
        HIGH_IDX: prdata_nxt[15:0] = high_r;
        default:  hit = 1'b0;
      endcase
      pslverr_nxt = ~hit;
    end
  end

  // engine and register next values
  always_comb begin
    seq_nxt   = seq_r;
    avg_nxt   = avg_r;
    ctrl_nxt  = ctrl_r;
    mask_nxt  = mask_r;
    trip_nxt  = trip_r;
    ref_nxt   = ref_r;
    low_nxt   = low_r;
    high_nxt  = high_r;
    stat_nxt  = stat_r;
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    pass_nxt  = pass_r;
    alo_nxt   = alo_r;
    ahi_nxt   = ahi_r;
    run_nxt   = run_r;
    lvl_nxt   = lvl_r;
    first_nxt = first_r;
    div_nxt   = tick ? 8'h00 : div_r + 8'h01;
    // software writes
    if (wr) begin
      unique case (idx)
        SEQ_IDX:  seq_nxt  = pwdata[7:0];
        AVG_IDX:  avg_nxt  = pwdata[7:0];
        CTRL_IDX: begin
          ctrl_nxt = pwdata[2:0];
          if (pwdata[AUTO_BIT] && !auto) begin
            first_nxt = 1'b1;
          end
        end
        STAT_IDX: stat_nxt = stat_r & ~pwdata[3:1];
        MASK_IDX: mask_nxt = pwdata[3:0];
        TRIP_IDX: trip_nxt = pwdata[15:0];
        REF_IDX:  ref_nxt  = pwdata[15:0];
        default:  ;
      endcase
    end
    // sequencer
    unique case (st_r)
      ST_IDLE: begin
        alo_nxt  = 21'h00_0000;
        ahi_nxt  = 21'h00_0000;
        pass_nxt = 5'd0;
        run_nxt  = 5'd0;
        if (ctrl_r[START_BIT] || auto) begin
          if (auto && ctrl_r[IDLE_EN_BIT]) begin
            st_nxt  = ST_DELAY;
            cnt_nxt = 17'((32'(idle_sel) + 1) * IDLE_UNIT - 1);
          end else begin
            st_nxt  = ST_SETTLE;
            cnt_nxt = 17'((32'(set_sel) + 1) * SETTLE_UNIT - 1);
          end
        end
      end
      ST_DELAY: begin
        if (tick) begin
          cnt_nxt = cnt_r - 17'd1;
          if (cnt_r == 17'd0) begin
            st_nxt  = ST_SETTLE;
            cnt_nxt = 17'((32'(set_sel) + 1) * SETTLE_UNIT - 1);
          end
        end
      end
      ST_SETTLE: begin
        if (tick) begin
          cnt_nxt = cnt_r - 17'd1;
          if (cnt_r == 17'd0) begin
            st_nxt  = ST_COUNT;
            cnt_nxt = tksc_cycles(avg_r[CYC_LSB+:3]) - 17'd1;
          end
        end
      end
      ST_COUNT: begin
        if (tick) begin
          cnt_nxt = cnt_r - 17'd1;
          lvl_nxt = s2_r;
          if (s2_r != lvl_r) begin
            run_nxt = 5'd0;
          end else if (run_r != 5'h1f) begin
            run_nxt = run_r + 5'd1;
          end
          if (noisy) begin
            stat_nxt[NOISE_BIT] = 1'b1;
          end else if (s2_r) begin
            ahi_nxt = ahi_r + 21'd1;
          end else begin
            alo_nxt = alo_r + 21'd1;
          end
          if (cnt_r == 17'd0) begin
            if (pass_r == pass_last) begin
              st_nxt = ST_DONE;
            end else begin
              pass_nxt = pass_r + 5'd1;
              cnt_nxt  = tksc_cycles(avg_r[CYC_LSB+:3]) - 17'd1;
            end
          end
        end
      end
      ST_DONE: begin
        st_nxt   = ST_IDLE;
        low_nxt  = low_sat;
        high_nxt = (ahi_r[20:16] != 5'd0) ? 16'hffff : ahi_r[15:0];
        if (auto) begin
          if (first_r && avg_r[REFERENCE_INIT_SEL_BIT]) begin
            ref_nxt = low_sat;
          end else begin
            ref_nxt = sum[15:0];
          end
          first_nxt = 1'b0;
          if (over) begin
            stat_nxt[TRIP_BIT] = 1'b1;
          end
        end else begin
          ctrl_nxt[START_BIT] = 1'b0;
          stat_nxt[DONE_BIT]  = 1'b1;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    irq_nxt  = |({stat_nxt, 1'b0} & mask_r);
    wake_nxt = stat_nxt[TRIP_BIT];
  end

  // sense synchroniser, first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= sense_in;
      s2_r <= s1_r;
    end
  end

  // register all state except the sense synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      seq_r     <= CFG_RST;
      avg_r     <= CFG_RST;
      ctrl_r    <= 3'h0;
      stat_r    <= 3'h0;
      mask_r    <= 4'h0;
      trip_r    <= WORD_RST;
      ref_r     <= WORD_RST;
      low_r     <= WORD_RST;
      high_r    <= WORD_RST;
      irq_r     <= 1'b0;
      wake_r    <= 1'b0;
      st_r      <= ST_IDLE;
      cnt_r     <= 17'h0_0000;
      pass_r    <= 5'd0;
      alo_r     <= 21'h00_0000;
      ahi_r     <= 21'h00_0000;
      run_r     <= 5'd0;
      lvl_r     <= 1'b0;
      first_r   <= 1'b0;
      div_r     <= 8'h00;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      seq_r     <= seq_nxt;
      avg_r     <= avg_nxt;
      ctrl_r    <= ctrl_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      trip_r    <= trip_nxt;
      ref_r     <= ref_nxt;
      low_r     <= low_nxt;
      high_r    <= high_nxt;
      irq_r     <= irq_nxt;
      wake_r    <= wake_nxt;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      pass_r    <= pass_nxt;
      alo_r     <= alo_nxt;
      ahi_r     <= ahi_nxt;
      run_r     <= run_nxt;
      lvl_r     <= lvl_nxt;
      first_r   <= first_nxt;
      div_r     <= div_nxt;
    end
  end

  // outputs straight from flops
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;
  assign wakeup  = wake_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence enter_settle;
    (st_r != ST_SETTLE) ##1 (st_r == ST_SETTLE);
  endsequence
  sequence enter_delay;
    (st_r == ST_IDLE) ##1 (st_r == ST_DELAY);
  endsequence
  sequence count_last;
    (st_r == ST_COUNT) && tick && (cnt_r == 17'd0);
  endsequence

  settle_load_a: assert property (enter_settle |->
    cnt_r == 17'((32'(set_sel) + 1) * SETTLE_UNIT - 1))
    else $error("settle length wrong");
  idle_load_a: assert property (enter_delay |->
    cnt_r == 17'((32'(idle_sel) + 1) * IDLE_UNIT - 1))
    else $error("idle length wrong");
  idle_gate_a: assert property (enter_delay |->
    $past(ctrl_r[IDLE_EN_BIT]) && $past(auto))
    else $error("idle inserted while disabled");
  seq_end_a: assert property (count_last ##1 (st_r == ST_DONE) |->
    $past(pass_r) == pass_last)
    else $error("repeat count wrong");
  cycle_end_a: assert property (count_last |=>
    (st_r == ST_DONE) || (cnt_r == tksc_cycles(avg_r[CYC_LSB+:3]) - 17'd1))
    else $error("conversion did not end at count");
  noise_run_a: assert property ((st_r == ST_COUNT) && tick && noisy
    && cnt_r != 17'd0 |=> cnt_r == $past(cnt_r) - 17'd1 && stat_r[NOISE_BIT])
    else $error("counter stalled in noise");
  filt_off_a: assert property (((nf_len == 2'd0) ||
    (auto && !avg_r[AUTOLF_BIT])) |-> !noisy)
    else $error("filter active while off");
  start_clr_a: assert property ((st_r == ST_DONE) && !auto && !wr
    |=> !ctrl_r[START_BIT] && stat_r[DONE_BIT])
    else $error("start not cleared");
  trip_wake_a: assert property ((st_r == ST_DONE) && auto && over
    |=> stat_r[TRIP_BIT] && wakeup)
    else $error("trip missed");
  ref_init_a: assert property ((st_r == ST_DONE) && auto && first_r
    && avg_r[REFERENCE_INIT_SEL_BIT] |=> ref_r == $past(low_sat))
    else $error("reference not loaded");
  irq_done_a: assert property ($rose(stat_r[DONE_BIT]) |->
    $past(st_r) == ST_DONE)
    else $error("done flag before end");
endmodule
`default_nettype wire

// ==== testbench/tksc_sense_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// electrode comparator stand-in: steady low, steady high or a slow square wave
module tksc_sense_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // pattern: 0 low, 1 high, 2 toggling every four cycles
  input  wire logic [1:0] mode,
  // comparator level towards the engine
  output logic            sense_in
);
  logic [2:0] ph_r;   // phase of the square wave
  logic [2:0] ph_nxt; // next phase

  // phase advances every cycle
  always_comb begin
    ph_nxt = ph_r + 3'h1;
  end

  // phase register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 3'h0;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  // runs of four cycles stay below the shortest noise length of eight ticks
  always_comb begin
    case (mode)
      2'h0:    sense_in = 1'b0;
      2'h1:    sense_in = 1'b1;
      default: sense_in = ph_r[2];
    endcase
  end
endmodule
`default_nettype wire

// ==== testbench/test_touch_key_sequence_config.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_touch_key_sequence_config;
  import tksc_pkg::*;
  // apb side
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [17:0] paddr   = 18'h0_0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // electrode and events
  logic        sense_in;
  logic        irq;
  logic        wakeup;
  logic [1:0]  mode    = 2'h0;
  // bookkeeping
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  // touch-key divider for this run, one tick per pclk keeps the run short
  localparam int DIV = 1;

  always #25 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  tksc_core #(.TK_DIV(DIV)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense_in(sense_in), .irq(irq), .wakeup(wakeup));
  tksc_sense_model model (.pclk(pclk), .presetn(presetn), .mode(mode), .sense_in(sense_in));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] d);
    logic e;
    apb(1'b0, idx, 32'h0000_0000, d, e);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    rd(idx, d);
    check(d, exp);
  endtask

  // wait for irq or wakeup, give up after lim cycles
  task automatic wait_ev(input logic on_wake, input int lim, output int t);
    int t0;
    t0 = cyc;
    while ((on_wake ? wakeup : irq) !== 1'b1 && cyc - t0 < lim) @(posedge pclk);
    t = cyc - t0;
  endtask

  // start on an even cycle so the tick phase is the same every run
  task automatic align;
    while (cyc[0]) @(posedge pclk);
  endtask

  // one software-started conversion
  task automatic conv(input logic [7:0] seqv, input logic [7:0] avgv, output logic [31:0] hi,
                      output logic [31:0] lo, output logic [31:0] st, output int t);
    logic [31:0] s;
    wr(SEQ_IDX, {24'h00_0000, seqv});
    wr(AVG_IDX, {24'h00_0000, avgv});
    wr(MASK_IDX, 32'h0000_0002);
    align;
    wr(CTRL_IDX, 32'h0000_0001);
    rd(STAT_IDX, s);
    check(32'(s[BUSY_BIT]), 32'h0000_0001);
    wait_ev(1'b0, 70000, t);
    check(32'(irq), 32'h0000_0001);
    rdc(CTRL_IDX, 32'h0000_0000);
    rd(STAT_IDX, st);
    rd(HIGH_IDX, hi);
    rd(LOW_IDX, lo);
    wr(STAT_IDX, 32'h0000_000f);
    rdc(CTRL_IDX, 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
  endtask

  // one auto-mode run, stopped after the first trip or after lim cycles
  // status is read while the engine has already restarted, so busy reads one
  task automatic auto_run(input logic [7:0] seqv, input logic [7:0] avgv, input logic [31:0] ctrlv,
                          input logic [15:0] trip, input logic [15:0] refv, input int lim,
                          input logic exp_trip, output int t, output logic [31:0] st,
                          output logic [31:0] rv);
    logic [31:0] s;
    wr(SEQ_IDX, {24'h00_0000, seqv});
    wr(AVG_IDX, {24'h00_0000, avgv});
    wr(TRIP_IDX, {16'h0000, trip});
    wr(REF_IDX, {16'h0000, refv});
    wr(MASK_IDX, 32'h0000_0004);
    align;
    wr(CTRL_IDX, ctrlv);
    wait_ev(1'b1, lim, t);
    check(32'(wakeup), 32'(exp_trip));
    check(32'(irq), 32'(exp_trip));
    rd(STAT_IDX, st);
    rd(REF_IDX, rv);
    wr(CTRL_IDX, 32'h0000_0000);
    s = 32'h0000_0001;
    for (int n = 0; n < 2000 && s[BUSY_BIT] !== 1'b0; n++) rd(STAT_IDX, s);
    check(32'(s[BUSY_BIT]), 32'h0000_0000);
    wr(STAT_IDX, 32'h0000_000f);
  endtask

  // reset values, read back, unmapped and read-only places
  task automatic t_regs;
    logic [31:0] d;
    logic        e;
    rdc(SEQ_IDX, 32'h0000_0000);
    rdc(AVG_IDX, 32'h0000_0000);
    rdc(STAT_IDX, 32'h0000_0000);
    wr(SEQ_IDX, 32'h0000_00a5);
    wr(AVG_IDX, 32'h0000_005a);
    rdc(SEQ_IDX, 32'h0000_00a5);
    rdc(AVG_IDX, 32'h0000_005a);
    apb(1'b0, 16'ha030, 32'h0000_0000, d, e);
    check(32'(e), 32'h0000_0001);
    check(d, 32'h0000_0000);
    wr(LOW_IDX, 32'h0000_ffff);
    rdc(LOW_IDX, 32'h0000_0000);
    $display("register test done");
  endtask

  // every repeat code, first one with cycle code 1
  task automatic t_repeat;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] st;
    int          t;
    mode <= 2'h1;
    for (int r = 0; r < 4; r++) begin
      conv({r[1:0], 6'h00}, (r == 0) ? 8'h08 : 8'h00, hi, lo, st, t);
      check(hi, (r == 0) ? 32'h0000_0800 : (32'h0000_0400 << (r + 1)));
      check(lo, 32'h0000_0000);
      check(st, 32'h0000_0002);
    end
    $display("repeat test done");
  endtask

  // settle time: code 3 adds twelve ticks to code 0, each tick DIV cycles
  task automatic t_settle;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] st;
    int          t0;
    int          t1;
    conv(8'h00, 8'h00, hi, lo, st, t0);
    conv(8'h30, 8'h00, hi, lo, st, t1);
    check(32'(t1 - t0), 32'(3 * SETTLE_UNIT * DIV));
    $display("settle test done");
  endtask

  // noise filter with short runs and with one long run
  task automatic t_noise;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] st;
    int          t0;
    int          t1;
    mode <= 2'h2;
    conv(8'h01, 8'h00, hi, lo, st, t0);
    check(hi + lo, 32'h0000_0400);
    check(st, 32'h0000_0002);
    mode <= 2'h1;
    conv(8'h01, 8'h00, hi, lo, st, t1);
    check(32'(hi + lo < 32'h0000_0400), 32'h0000_0001);
    check(st, 32'h0000_000a);
    check(32'(t1), 32'(t0));
    $display("noise test done");
  endtask

  // auto mode: trip, idle delay, averaging, initial value, compare select, filter
  task automatic t_auto;
    logic [31:0] st;
    logic [31:0] rv;
    int          t0;
    int          t1;
    mode <= 2'h0;
    auto_run(8'h04, 8'h00, 32'h0000_0002, 16'h03ff, 16'h0000, 5000, 1'b1, t0, st, rv);
    check(st, 32'h0000_0005);
    check(rv, 32'h0000_0020);
    auto_run(8'h04, 8'h00, 32'h0000_0006, 16'h03ff, 16'h0000, 5000, 1'b1, t1, st, rv);
    check(32'(t1 - t0), 32'(2 * IDLE_UNIT * DIV));
    auto_run(8'h00, 8'hc0, 32'h0000_0002, 16'h0000, 16'h0000, 5000, 1'b1, t0, st, rv);
    check(rv, 32'h0000_0004);
    auto_run(8'h00, 8'h04, 32'h0000_0002, 16'h0000, 16'h0000, 5000, 1'b1, t0, st, rv);
    check(rv, 32'h0000_0400);
    auto_run(8'h00, 8'h02, 32'h0000_0002, 16'h0000, 16'h0400, 2500, 1'b0, t0, st, rv);
    check(st, 32'h0000_0001);
    mode <= 2'h1;
    auto_run(8'h01, 8'h01, 32'h0000_0002, 16'hffff, 16'h0000, 2500, 1'b0, t0, st, rv);
    check(st, 32'h0000_0009);
    auto_run(8'h01, 8'h00, 32'h0000_0002, 16'hffff, 16'h0000, 2500, 1'b0, t0, st, rv);
    check(st, 32'h0000_0001);
    $display("auto test done");
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_repeat;
    t_settle;
    t_noise;
    t_auto;
    report_and_stop;
  end

  // watchdog against a hang, about 80000 cycles against some 54000 needed
  initial begin
    #4_000_000;
    miscompares++;
    report_and_stop;
  end
endmodule
`default_nettype wire
